// ---- rtl/eeac_array.sv ----
// Data EEPROM array with its own write timer.
// Assumes the controller starts one write at a time and aborts on reset.
`timescale 1ns/1ns
module eeac_array
  import eeac_pkg::*;
#(
  parameter int WR_CYC = EEAC_WR_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Write request
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  // Read port
  input wire logic [7:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  // Status
  output logic busy_o,
  output logic done_o
);

  eeac_wr_t state_q;
  logic [EEAC_CNT_W-1:0] cnt_q;
  logic [7:0] addr_q;
  logic [7:0] data_q;
  logic [7:0] mem_q [256];
  logic half_w;
  logic end_w;

  localparam logic [EEAC_CNT_W-1:0] HALF = EEAC_CNT_W'(WR_CYC / 2);
  localparam logic [EEAC_CNT_W-1:0] LAST = EEAC_CNT_W'(WR_CYC - 1);

  assign rd_data_o = mem_q[rd_addr_i];
  assign busy_o = (state_q != EEAC_WR_IDLE);
  assign half_w = (cnt_q == HALF);
  assign end_w = (cnt_q == LAST);

  // --------------------------------------------------------------------
  // Write timer: erase first half, program at the end
  // --------------------------------------------------------------------
  // Address and data are latched at start so software may reload the
  // registers while the cell is still being written.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= EEAC_WR_IDLE;
      cnt_q <= '0;
      addr_q <= EEAC_RST_BYTE;
      data_q <= EEAC_RST_BYTE;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (abort_i) begin
        state_q <= EEAC_WR_IDLE;
        cnt_q <= '0;
      end else begin
        unique case (state_q)
          EEAC_WR_IDLE: begin
            if (start_i) begin
              state_q <= EEAC_WR_ERASE;
              cnt_q <= '0;
              addr_q <= wr_addr_i;
              data_q <= wr_data_i;
            end
          end
          EEAC_WR_ERASE: begin
            cnt_q <= cnt_q + 1'b1;
            if (half_w) begin
              state_q <= EEAC_WR_PROGRAM;
            end
          end
          EEAC_WR_PROGRAM: begin
            cnt_q <= cnt_q + 1'b1;
            if (end_w) begin
              state_q <= EEAC_WR_IDLE;
              done_o <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Cell storage
  // --------------------------------------------------------------------
  // Contents survive resets, as a nonvolatile array should.
  always_ff @(posedge sys_clk_i) begin
    if (!abort_i && state_q == EEAC_WR_ERASE && cnt_q == '0) begin
      mem_q[addr_q] <= EEAC_ERASED;
    end else if (!abort_i && state_q == EEAC_WR_PROGRAM && end_w) begin
      mem_q[addr_q] <= data_q;
    end
  end

endmodule : eeac_array

// ---- rtl/eeac_pkg.sv ----
// Constants shared by the nonvolatile access controller and its array.
// Assumes a single 20 MHz core clock and an APB register port.
package eeac_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] EEAC_OFF_DATA_LOW  = 8'h00;
  localparam logic [7:0] EEAC_OFF_ADDR_LOW  = 8'h04;
  localparam logic [7:0] EEAC_OFF_DATA_HIGH = 8'h08;
  localparam logic [7:0] EEAC_OFF_ADDR_HIGH = 8'h0c;
  localparam logic [7:0] EEAC_OFF_CONTROL   = 8'h10;
  localparam logic [7:0] EEAC_OFF_KEY_PORT  = 8'h14;
  localparam logic [7:0] EEAC_OFF_STATUS    = 8'h18;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int EEAC_BIT_RD_TRIG = 0;
  localparam int EEAC_BIT_WR_TRIG = 1;
  localparam int EEAC_BIT_UNLOCK  = 2;
  localparam int EEAC_BIT_ABORT   = 3;
  localparam int EEAC_BIT_PSEL    = 7;
  localparam int EEAC_BIT_DONE    = 0;
  localparam int EEAC_BIT_PWRT_OK = 1;
  localparam int EEAC_ADDR_HI_W   = 4;
  localparam int EEAC_DATA_HI_W   = 6;
  localparam int EEAC_PROG_W      = 14;
  localparam int EEAC_PADDR_W     = 12;

  // ----------------------------------------------------------------------
  // Reset values and keys
  // ----------------------------------------------------------------------
  localparam logic [7:0] EEAC_RST_BYTE   = 8'h00;
  localparam logic [7:0] EEAC_ERASED     = 8'hff;
  localparam logic [7:0] EEAC_KEY_FIRST  = 8'h55;
  localparam logic [7:0] EEAC_KEY_SECOND = 8'haa;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int EEAC_CLK_KHZ     = 20000;
  localparam int EEAC_PWRT_MS     = 64;
  localparam int EEAC_PWRT_CYC    = EEAC_PWRT_MS * EEAC_CLK_KHZ;
  localparam int EEAC_WR_TIME_US  = 5000;
  localparam int EEAC_WR_CYC      = EEAC_WR_TIME_US * EEAC_CLK_KHZ / 1000;
  localparam int EEAC_CNT_W       = 21;

  typedef enum logic [1:0] {
    EEAC_KEY_IDLE,
    EEAC_KEY_GOT_FIRST,
    EEAC_KEY_ARMED
  } eeac_key_t;

  typedef enum logic [1:0] {
    EEAC_WR_IDLE,
    EEAC_WR_ERASE,
    EEAC_WR_PROGRAM
  } eeac_wr_t;

endpackage : eeac_pkg

// ---- rtl/eeac_top.sv ----
// Nonvolatile access controller: APB registers over data EEPROM and
// program flash. Assumes reset pins arrive asynchronously and the flash
// read port sits on the core clock.
// Function
// - program_select picks data (0) or program (1) memory; reset clears it.
// - Program memory is read only; write_trigger is ignored when selected.
// - Triggers are set-only by software and cleared by hardware at finish.
// - Data writes need write_unlock set; it is 0 after power-up.
// - write_abort_flag set when reset cuts a write short; 0 on completion.
// - write_done_flag set at write completion, cleared only by software.
// - unlock_key_port has no storage and always reads zero.
// - Data read: addressed byte lands in nv_data_low the next cycle.
// - nv_data_low holds until another read, a software write or a reset.
// - Write starts only after 55h, AAh, then write_trigger, back to back.
// - write_trigger cannot be set while write_unlock is 0.
// - Clearing write_unlock does not stop a started write.
// - Hardware never clears write_unlock; only software or power-up.
// - Program address 4+8 bits; 6 high data bits; unused bits read 0.
// - Each byte write erases the cell before programming it.
// - Write duration is timed internally.
// - Program read fetches in second cycle, data in both registers next.
// - Writes blocked while the 64 ms power-up timer runs.
`timescale 1ns/1ns
module eeac_top
  import eeac_pkg::*;
#(
  parameter int PWRT_CYC = EEAC_PWRT_CYC,
  parameter int WR_CYC = EEAC_WR_CYC
) (
  // Clock and power-on reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Other reset sources, asynchronous
  input wire logic ext_reset_i,
  input wire logic wdt_reset_i,
  input wire logic bor_reset_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Program flash read port
  output logic [EEAC_PADDR_W-1:0] prog_addr_o,
  output logic prog_rd_o,
  input wire logic [EEAC_PROG_W-1:0] prog_data_i,
  // Completion level for the interrupt controller
  output logic write_done_flag_o
);

  // --------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------
  function automatic logic known_off(input logic [7:0] a);
    known_off = (a == EEAC_OFF_DATA_LOW) || (a == EEAC_OFF_ADDR_LOW) ||
                (a == EEAC_OFF_DATA_HIGH) || (a == EEAC_OFF_ADDR_HIGH) ||
                (a == EEAC_OFF_CONTROL) || (a == EEAC_OFF_KEY_PORT) ||
                (a == EEAC_OFF_STATUS);
  endfunction : known_off

  // --------------------------------------------------------------------
  // Reset source synchronisers
  // --------------------------------------------------------------------
  logic [2:0] rsrc_meta_q;
  logic [2:0] rsrc_sync_q;
  logic soft_rst_w;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsrc_meta_q <= 3'h0;
      rsrc_sync_q <= 3'h0;
    end else begin
      rsrc_meta_q <= {bor_reset_i, wdt_reset_i, ext_reset_i};
      rsrc_sync_q <= rsrc_meta_q;
    end
  end

  assign soft_rst_w = |rsrc_sync_q;

  // --------------------------------------------------------------------
  // APB access decode
  // --------------------------------------------------------------------
  logic access_w;
  logic wr_w;
  logic setup_w;
  logic [7:0] wbyte_w;
  logic wr_dlo_w;
  logic wr_alo_w;
  logic wr_dhi_w;
  logic wr_ahi_w;
  logic wr_ctl_w;
  logic wr_key_w;
  logic wr_sts_w;

  assign access_w = psel_i && penable_i && pready_o;
  assign wr_w = access_w && pwrite_i;
  assign setup_w = psel_i && !penable_i;
  assign wbyte_w = pwdata_i[7:0];
  assign wr_dlo_w = wr_w && (paddr_i == EEAC_OFF_DATA_LOW);
  assign wr_alo_w = wr_w && (paddr_i == EEAC_OFF_ADDR_LOW);
  assign wr_dhi_w = wr_w && (paddr_i == EEAC_OFF_DATA_HIGH);
  assign wr_ahi_w = wr_w && (paddr_i == EEAC_OFF_ADDR_HIGH);
  assign wr_ctl_w = wr_w && (paddr_i == EEAC_OFF_CONTROL);
  assign wr_key_w = wr_w && (paddr_i == EEAC_OFF_KEY_PORT);
  assign wr_sts_w = wr_w && (paddr_i == EEAC_OFF_STATUS);

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  logic [7:0] data_lo_q;
  logic [7:0] addr_lo_q;
  logic [EEAC_DATA_HI_W-1:0] data_hi_q;
  logic [EEAC_ADDR_HI_W-1:0] addr_hi_q;
  logic psel_q;
  logic abort_q;
  logic unlock_q;
  logic wr_trig_q;
  logic rd_trig_q;
  logic [1:0] rd_cnt_q;
  logic done_q;
  logic pwrt_ok_q;
  logic [EEAC_CNT_W-1:0] pwrt_cnt_q;
  eeac_key_t key_q;

  logic [7:0] arr_rd_w;
  logic arr_busy_w;
  logic arr_done_w;
  logic start_w;
  logic rd_req_w;
  logic prog_rd_req_w;
  logic data_rd_done_w;
  logic prog_rd_done_w;
  logic [7:0] ctl_rd_w;
  logic [7:0] sts_rd_w;
  logic [7:0] rd_byte_w;

  // A write is only honoured straight after the second key, with the
  // array idle, unlock already set, data memory selected and the
  // power-up timer expired.
  assign start_w = wr_ctl_w && wbyte_w[EEAC_BIT_WR_TRIG] &&
                   !wbyte_w[EEAC_BIT_PSEL] &&
                   unlock_q &&
                   (key_q == EEAC_KEY_ARMED) &&
                   pwrt_ok_q &&
                   !wr_trig_q && !rd_trig_q && !soft_rst_w;
  assign rd_req_w = wr_ctl_w && wbyte_w[EEAC_BIT_RD_TRIG] &&
                    !rd_trig_q && !wr_trig_q && !start_w && !soft_rst_w;
  assign prog_rd_req_w = psel_q;
  assign data_rd_done_w = rd_trig_q && !psel_q;
  assign prog_rd_done_w = rd_trig_q && psel_q && (rd_cnt_q == 2'h2);

  // --------------------------------------------------------------------
  // Unlock key sequencer
  // --------------------------------------------------------------------
  // Any other completed access in between breaks the sequence.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      key_q <= EEAC_KEY_IDLE;
    end else if (soft_rst_w) begin
      key_q <= EEAC_KEY_IDLE;
    end else if (access_w) begin
      if (wr_key_w && wbyte_w == EEAC_KEY_FIRST) begin
        key_q <= EEAC_KEY_GOT_FIRST;
      end else if (wr_key_w && wbyte_w == EEAC_KEY_SECOND &&
                   key_q == EEAC_KEY_GOT_FIRST) begin
        key_q <= EEAC_KEY_ARMED;
      end else begin
        key_q <= EEAC_KEY_IDLE;
      end
    end
  end

  // --------------------------------------------------------------------
  // Power-up timer
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwrt_cnt_q <= '0;
      pwrt_ok_q <= 1'b0;
    end else if (!pwrt_ok_q) begin
      pwrt_cnt_q <= pwrt_cnt_q + 1'b1;
      pwrt_ok_q <= (pwrt_cnt_q == EEAC_CNT_W'(PWRT_CYC - 1));
    end
  end

  // --------------------------------------------------------------------
  // Control bits
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      psel_q <= 1'b0;
      unlock_q <= 1'b0;
      abort_q <= 1'b0;
      wr_trig_q <= 1'b0;
      rd_trig_q <= 1'b0;
      rd_cnt_q <= 2'h0;
    end else if (soft_rst_w) begin
      // Unlock survives these resets; only power-up clears it.
      psel_q <= 1'b0;
      wr_trig_q <= 1'b0;
      rd_trig_q <= 1'b0;
      rd_cnt_q <= 2'h0;
      if (arr_busy_w) begin
        abort_q <= 1'b1;
      end
    end else begin
      if (wr_ctl_w) begin
        psel_q <= wbyte_w[EEAC_BIT_PSEL];
        unlock_q <= wbyte_w[EEAC_BIT_UNLOCK];
      end
      if (arr_done_w) begin
        abort_q <= 1'b0;
      end else if (wr_ctl_w) begin
        abort_q <= wbyte_w[EEAC_BIT_ABORT];
      end
      if (start_w) begin
        wr_trig_q <= 1'b1;
      end else if (arr_done_w) begin
        wr_trig_q <= 1'b0;
      end
      if (rd_req_w) begin
        rd_trig_q <= 1'b1;
        rd_cnt_q <= 2'h0;
      end else if (data_rd_done_w || prog_rd_done_w) begin
        rd_trig_q <= 1'b0;
      end else if (rd_trig_q) begin
        rd_cnt_q <= rd_cnt_q + 2'h1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Address and data registers
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_lo_q <= EEAC_RST_BYTE;
      addr_lo_q <= EEAC_RST_BYTE;
      data_hi_q <= '0;
      addr_hi_q <= '0;
    end else if (soft_rst_w) begin
      data_lo_q <= EEAC_RST_BYTE;
      addr_lo_q <= EEAC_RST_BYTE;
      data_hi_q <= '0;
      addr_hi_q <= '0;
    end else begin
      if (data_rd_done_w) begin
        data_lo_q <= arr_rd_w;
      end else if (prog_rd_done_w) begin
        data_lo_q <= prog_data_i[7:0];
      end else if (wr_dlo_w) begin
        data_lo_q <= wbyte_w;
      end
      if (prog_rd_done_w) begin
        data_hi_q <= prog_data_i[EEAC_PROG_W-1:8];
      end else if (wr_dhi_w) begin
        data_hi_q <= wbyte_w[EEAC_DATA_HI_W-1:0];
      end
      if (wr_alo_w) begin
        addr_lo_q <= wbyte_w;
      end
      if (wr_ahi_w) begin
        addr_hi_q <= wbyte_w[EEAC_ADDR_HI_W-1:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // Completion flag
  // --------------------------------------------------------------------
  // The hardware set wins over a same-cycle write-one-to-clear.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_q <= 1'b0;
    end else if (arr_done_w) begin
      done_q <= 1'b1;
    end else if (wr_sts_w && wbyte_w[EEAC_BIT_DONE]) begin
      done_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Program flash port
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prog_addr_o <= '0;
      prog_rd_o <= 1'b0;
    end else begin
      prog_addr_o <= {addr_hi_q, addr_lo_q};
      prog_rd_o <= rd_trig_q && prog_rd_req_w && (rd_cnt_q == 2'h0) &&
                   !soft_rst_w;
    end
  end

  // --------------------------------------------------------------------
  // Read mux and APB answer
  // --------------------------------------------------------------------
  assign ctl_rd_w = {psel_q, 3'h0, abort_q, unlock_q, wr_trig_q, rd_trig_q};
  assign sts_rd_w = {6'h0, pwrt_ok_q, done_q};
  assign rd_byte_w =
    (paddr_i == EEAC_OFF_DATA_LOW)  ? data_lo_q :
    (paddr_i == EEAC_OFF_ADDR_LOW)  ? addr_lo_q :
    (paddr_i == EEAC_OFF_DATA_HIGH) ? {2'h0, data_hi_q} :
    (paddr_i == EEAC_OFF_ADDR_HIGH) ? {4'h0, addr_hi_q} :
    (paddr_i == EEAC_OFF_CONTROL)   ? ctl_rd_w :
    (paddr_i == EEAC_OFF_STATUS)    ? sts_rd_w :
    8'h00;

  // Data is sampled in the setup cycle so every output stays a flop; the
  // access phase therefore always lasts exactly one cycle.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= setup_w;
      pslverr_o <= setup_w && !known_off(paddr_i);
      if (setup_w) begin
        prdata_o <= {24'h0, rd_byte_w};
      end
    end
  end

  // The completion level follows the flag's next value so it stays a flop.

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      write_done_flag_o <= 1'b0;
    end else begin
      write_done_flag_o <= arr_done_w || (done_q &&
                           !(wr_sts_w && wbyte_w[EEAC_BIT_DONE]));
    end
  end

  // --------------------------------------------------------------------
  // Data EEPROM array
  // --------------------------------------------------------------------
  eeac_array #(
    .WR_CYC(WR_CYC)
  ) u_array (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(start_w),
    .abort_i(soft_rst_w),
    .wr_addr_i(addr_lo_q),
    .wr_data_i(data_lo_q),
    .rd_addr_i(addr_lo_q),
    .rd_data_o(arr_rd_w),
    .busy_o(arr_busy_w),
    .done_o(arr_done_w)
  );

endmodule : eeac_top

// ---- tb/eeac_top_chk.sv ----
// Checker on the register port and flash strobe of the access controller.
// Assumes one-cycle APB answers and a single core clock.
`timescale 1ns/1ns
module eeac_top_chk
  import eeac_pkg::*;
#(
  parameter int PWRT_CYC = EEAC_PWRT_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  // Flash port and completion
  input wire logic prog_rd_o,
  input wire logic [EEAC_PADDR_W-1:0] prog_addr_o,
  input wire logic write_done_flag_o
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [31:0] up_cnt_q;
  wire [31:0] up_cnt_d = (up_cnt_q < 32'h0000ffff) ? up_cnt_q + 1 : up_cnt_q;
  wire rd_setup = psel_i && !penable_i && !pwrite_i;
  wire rd_stat = rd_setup && paddr_i == EEAC_OFF_STATUS;
  wire clr_done = psel_i && penable_i && pwrite_i &&
    paddr_i == EEAC_OFF_STATUS && pwdata_i[EEAC_BIT_DONE];
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_cnt_q <= '0;
    end else begin
      up_cnt_q <= up_cnt_d;
    end
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  chk_key_zero: assert property (
    rd_setup && paddr_i == EEAC_OFF_KEY_PORT |=> prdata_o == 32'h0)
    else $error("key port read not zero");
  chk_datah_unused: assert property (
    rd_setup && paddr_i == EEAC_OFF_DATA_HIGH |=> prdata_o[31:6] == '0)
    else $error("data high unused bits set");
  chk_addrh_unused: assert property (
    rd_setup && paddr_i == EEAC_OFF_ADDR_HIGH |=> prdata_o[31:4] == '0)
    else $error("address high unused bits set");
  chk_ctrl_unused: assert property (
    rd_setup && paddr_i == EEAC_OFF_CONTROL |=> prdata_o[6:4] == 3'h0)
    else $error("control unused bits set");
  chk_prog_pulse: assert property (
    prog_rd_o |=> !prog_rd_o)
    else $error("flash strobe longer than one cycle");
  chk_prog_addr_hold: assert property (
    prog_rd_o |=> $stable(prog_addr_o))
    else $error("flash address moved during fetch");
  chk_done_sticky: assert property (
    $fell(write_done_flag_o) |-> $past(clr_done) || $past(clr_done, 2))
    else $error("done flag cleared without software");
  chk_pwrt_block: assert property (
    rd_stat && up_cnt_q + 4 < PWRT_CYC |=> !prdata_o[EEAC_BIT_PWRT_OK])
    else $error("power-up timer ended early");
  chk_pwrt_end: assert property (
    rd_stat && up_cnt_q > PWRT_CYC + 4 |=> prdata_o[EEAC_BIT_PWRT_OK])
    else $error("power-up timer never ended");
endmodule : eeac_top_chk

bind eeac_top eeac_top_chk #(.PWRT_CYC(PWRT_CYC)) eeac_top_chk_inst (
  .sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .prdata_o(prdata_o),
  .prog_rd_o(prog_rd_o),
  .prog_addr_o(prog_addr_o),
  .write_done_flag_o(write_done_flag_o)
);

// ---- tb/eeac_top_tb.sv ----
// Self-checking bench for the access controller, driven over APB.
// Assumes short power-up and write counts set by parameter.
`timescale 1ns/1ns
module eeac_top_tb
  import eeac_pkg::*;
;
  // ---------------------------------------------------------------
  // Stimulus and design
  // ---------------------------------------------------------------
  localparam int PW = 60;
  localparam int WR = 16;
  localparam logic [13:0] WORD = 14'h2d3c;
  localparam logic [7:0] K = EEAC_OFF_KEY_PORT;
  localparam logic [7:0] C = EEAC_OFF_CONTROL;
  localparam logic [7:0] D = EEAC_OFF_DATA_LOW;
  // Each row holds four address and data pairs, then the control read.
  localparam logic [7:0] SQ [0:3][0:8] = '{
    '{C, 8'h00, K, 8'h55, K, 8'haa, C, 8'h02, 8'h00},
    '{K, 8'h55, C, 8'h04, K, 8'haa, C, 8'h06, 8'h04},
    '{K, 8'h55, K, 8'haa, K, 8'h55, C, 8'h06, 8'h04},
    '{C, 8'h84, K, 8'h55, K, 8'haa, C, 8'h86, 8'h84}};
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] soft_rst = 3'h0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [13:0] prog_data_i = 14'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [11:0] prog_addr_o;
  logic prog_rd_o;
  logic write_done_flag_o;
  logic err_q;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  // The flash returns the word only at the address under test.
  always @(posedge sys_clk_i) begin
    prog_data_i <= (prog_addr_o === 12'ha5c) ? WORD : 14'h0;
  end
  eeac_top #(.PWRT_CYC(PW), .WR_CYC(WR)) eeac_top_inst (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ext_reset_i(soft_rst[0]),
    .wdt_reset_i(soft_rst[1]),
    .bor_reset_i(soft_rst[2]),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .prog_addr_o(prog_addr_o),
    .prog_rd_o(prog_rd_o),
    .prog_data_i(prog_data_i),
    .write_done_flag_o(write_done_flag_o)
  );
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    @(posedge sys_clk_i);
    while (pready_o !== 1'b1) @(posedge sys_clk_i);
    q = prdata_o;
    err_q = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask : rd
  task automatic start_wr(input logic [7:0] ctl);
    wr(K, EEAC_KEY_FIRST);
    wr(K, EEAC_KEY_SECOND);
    wr(C, ctl);
  endtask : start_wr
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 7; i++) rd(8'(4 * i), 32'h0);
    wr(C, 8'h04);
    start_wr(8'h06);
    rd(C, 32'h04);
    rd(8'h1c, 32'h0);
    chk(32'(err_q), 32'h1);
    $display("test reset and guard done");
    repeat (PW) @(posedge sys_clk_i);
    rd(EEAC_OFF_STATUS, 32'h2);
    wr(EEAC_OFF_ADDR_LOW, 8'h3c);
    wr(D, 8'ha5);
    start_wr(8'h06);
    rd(C, 32'h06);
    wr(C, 8'h00);
    rd(C, 32'h02);
    for (int n = 0; n < WR * 4 && write_done_flag_o !== 1'b1; n++) begin
      @(posedge sys_clk_i);
    end
    chk(32'(write_done_flag_o), 32'h1);
    rd(C, 32'h00);
    wr(EEAC_OFF_STATUS, 8'h00);
    rd(EEAC_OFF_STATUS, 32'h3);
    wr(EEAC_OFF_STATUS, 8'h01);
    rd(EEAC_OFF_STATUS, 32'h2);
    wr(D, 8'h00);
    wr(C, 8'h01);
    rd(D, 32'ha5);
    rd(C, 32'h00);
    $display("test data write and read done");
    for (int c = 0; c < 4; c++) begin
      for (int j = 0; j < 4; j++) wr(SQ[c][2 * j], SQ[c][2 * j + 1]);
      rd(C, {24'h0, SQ[c][8]});
    end
    repeat (WR * 2) @(posedge sys_clk_i);
    chk(32'(write_done_flag_o), 32'h0);
    $display("test refused writes done");
    wr(EEAC_OFF_ADDR_HIGH, 8'h1a);
    rd(EEAC_OFF_ADDR_HIGH, 32'h0a);
    wr(EEAC_OFF_ADDR_LOW, 8'h5c);
    wr(C, 8'h81);
    repeat (3) @(posedge sys_clk_i);
    rd(D, 32'h3c);
    rd(EEAC_OFF_DATA_HIGH, 32'h2d);
    chk(32'(prog_addr_o), 32'ha5c);
    rd(C, 32'h80);
    $display("test program read done");
    for (int i = 0; i < 3; i++) begin
      wr(C, 8'h04);
      start_wr(8'h06);
      repeat (4) @(posedge sys_clk_i);
      soft_rst <= 3'(1 << i);
      repeat (4) @(posedge sys_clk_i);
      soft_rst <= 3'h0;
      repeat (4) @(posedge sys_clk_i);
      rd(C, 32'h0c);
      chk(32'(write_done_flag_o), 32'h0);
    end
    $display("test abort done");
    conclude();
  end
endmodule : eeac_top_tb
